// *** hdl/bsag_pkg.sv ***
/*
 * Shared constants for the clock-recovery gain and gain-limit configuration bank:
 * register offsets, field positions, reset values and the phase enumeration.
 * Assumes a byte-wide register port with six-bit addresses, as the serial port uses.
 */
package bsag_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register map.
   ////////////////////////////////////////////////////////////////////////////////

   // Address width and data width of the register port.
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 8;

   // Clock-recovery gain and data-rate limit register.
   localparam logic [5:0] CLK_REC_GAIN_CFG_ADDR = 6'h19;
   // Gain cap and amplitude target register.
   localparam logic [5:0] GAIN_LIMIT_TGT_CFG_ADDR = 6'h1a;

   // Value returned for an address that holds no register here.
   localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions (low bit of each field).
   ////////////////////////////////////////////////////////////////////////////////

   localparam int unsigned PRE_KI_LSB   = 6;
   localparam int unsigned PRE_KP_LSB   = 4;
   localparam int unsigned POST_KI_BIT  = 3;
   localparam int unsigned POST_KP_BIT  = 2;
   localparam int unsigned SAT_LSB      = 0;
   localparam int unsigned DIGITAL_VGA_CAP_LSB = 6;
   localparam int unsigned FAMP_CAP_LSB = 3;
   localparam int unsigned AMP_TGT_LSB  = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // Field reset values.
   ////////////////////////////////////////////////////////////////////////////////

   localparam logic [1:0] PRE_KI_RST   = 2'h1;
   localparam logic [1:0] PRE_KP_RST   = 2'h2;
   localparam logic       POST_KI_RST  = 1'b1;
   localparam logic       POST_KP_RST  = 1'b1;
   localparam logic [1:0] SAT_RST      = 2'h0;
   localparam logic [1:0] DIGITAL_VGA_CAP_RST = 2'h0;
   localparam logic [2:0] FAMP_CAP_RST = 3'h0;
   localparam logic [2:0] AMP_TGT_RST  = 3'h3;

   ////////////////////////////////////////////////////////////////////////////////
   // Gain control ranges.
   ////////////////////////////////////////////////////////////////////////////////

   // Highest index of the digital VGA gain steps available to gain control.
   localparam logic [2:0] DIGITAL_VGA_TOP_SETTING = 3'h7;

   // Reception phase as seen by the clock-recovery loop.
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_PRE_SYNC,
      PH_POST_SYNC
   } bsag_phase_t;

endpackage

// *** hdl/bsag_loop_gain.sv ***
/*
 * Clock-recovery loop gain selector.
 * Turns the latched gain fields and the sync state into the integral and
 * proportional multipliers used by the loop. Assumes all inputs are on one clock.
 */
`timescale 1ns/1ps
module bsag_loop_gain (
   input  wire logic [1:0] i_pre_ki,     // Pre-sync integral gain code.
   input  wire logic [1:0] i_pre_kp,     // Pre-sync proportional gain code.
   input  wire logic       i_post_ki,    // Post-sync integral gain select.
   input  wire logic       i_post_kp,    // Post-sync proportional gain select.
   input  wire logic       i_post_sync,  // High once a sync word has been seen.
   output logic      [3:0] o_ki_halves,  // Integral gain in halves of the base gain.
   output logic      [2:0] o_kp_mult     // Proportional gain in multiples of base gain.
);

   ////////////////////////////////////////////////////////////////////////////////
   // Pre-sync gains.
   ////////////////////////////////////////////////////////////////////////////////

   logic [3:0] pre_ki_halves;  // Codes 0..3 give 1..4 times base, held in halves.
   logic [2:0] pre_kp_mult;    // Codes 0..3 give 1..4 times base.

   assign pre_ki_halves = {1'b0, i_pre_ki, 1'b0} + 4'h2;
   assign pre_kp_mult = {1'b0, i_pre_kp} + 3'h1;

   ////////////////////////////////////////////////////////////////////////////////
   // Phase-dependent selection.
   ////////////////////////////////////////////////////////////////////////////////

   // Picks the gain pair that applies in the current phase.
   always_comb begin
      o_ki_halves = pre_ki_halves;
      o_kp_mult   = pre_kp_mult;
      if (i_post_sync) begin
         if (i_post_ki) begin
            o_ki_halves = 4'h1;
         end
         if (i_post_kp) begin
            o_kp_mult = 3'h1;
         end
      end
   end

endmodule

// *** hdl/bsag_config_top.sv ***
/*
 * Clock-recovery gain and gain-limit configuration bank.
 * Holds the two byte registers, latches them at each reception start and drives
 * the effective loop gains, data-rate limit, gain caps and amplitude target.
 * Assumes the register port and the reception events come from logic on the
 * same 100 MHz clock, so no synchronisers are placed on them.
 */
`timescale 1ns/1ps
module bsag_config_top (
   input  wire logic       i_sys_clk,        // System clock, 100 MHz.
   input  wire logic       i_rst_n,          // Asynchronous reset, active low.
   input  wire logic [5:0] i_reg_addr,       // Register address.
   input  wire logic       i_reg_wr,         // Write strobe, one cycle.
   input  wire logic [7:0] i_reg_wdata,      // Write data.
   input  wire logic       i_reg_rd,         // Read strobe, one cycle.
   output logic      [7:0] o_reg_rdata,      // Read data, valid the cycle after i_reg_rd.
   input  wire logic       i_rx_start,       // Reception start pulse.
   input  wire logic       i_rx_end,         // Reception end pulse.
   input  wire logic       i_sync_det,       // Sync word detected pulse.
   output logic            o_post_sync,      // High while post-sync gains apply.
   output logic      [3:0] o_ki_halves,      // Integral gain in halves of base.
   output logic      [2:0] o_kp_mult,        // Proportional gain in multiples of base.
   output logic      [2:0] o_rate_limit,     // Data-rate limit in 1/32 steps, 0 = none.
   output logic      [2:0] o_digital_vga_max,       // Highest digital VGA setting allowed.
   output logic      [7:0] o_famp_atten_dd,  // Front amplifier cap in tenths of dB.
   output logic      [5:0] o_amp_target_db   // Amplitude target in dB.
);

   ////////////////////////////////////////////////////////////////////////////////
   // Decode functions.
   ////////////////////////////////////////////////////////////////////////////////

   // Data-rate limit in 1/32 of the rate: codes give 0, 1, 2 and 4 steps.
   function automatic logic [2:0] rate_limit_steps(input logic [1:0] code);
      logic [2:0] steps;
      steps = 3'h0;
      case (code)
         2'h1: begin
            steps = 3'h1;
         end
         2'h2: begin
            steps = 3'h2;
         end
         2'h3: begin
            steps = 3'h4;
         end
         default: begin
            steps = 3'h0;
         end
      endcase
      return steps;
   endfunction

   // Front amplifier cap below maximum gain, in tenths of a dB.
   function automatic logic [7:0] famp_atten(input logic [2:0] code);
      logic [7:0] dd;
      dd = 8'h00;
      case (code)
         3'h1: begin
            dd = 8'h1a;  // 2.6 dB.
         end
         3'h2: begin
            dd = 8'h3d;  // 6.1 dB.
         end
         3'h3: begin
            dd = 8'h4a;  // 7.4 dB.
         end
         3'h4: begin
            dd = 8'h5c;  // 9.2 dB.
         end
         3'h5: begin
            dd = 8'h73;  // 11.5 dB.
         end
         3'h6: begin
            dd = 8'h92;  // 14.6 dB.
         end
         3'h7: begin
            dd = 8'hab;  // 17.1 dB.
         end
         default: begin
            dd = 8'h00;  // Maximum possible gain.
         end
      endcase
      return dd;
   endfunction

   // Averaged channel-filter amplitude target in dB.
   function automatic logic [5:0] amp_target_db(input logic [2:0] code);
      logic [5:0] db;
      db = 6'h18;
      case (code)
         3'h1: begin
            db = 6'h1b;  // 27 dB.
         end
         3'h2: begin
            db = 6'h1e;  // 30 dB.
         end
         3'h3: begin
            db = 6'h21;  // 33 dB.
         end
         3'h4: begin
            db = 6'h24;  // 36 dB.
         end
         3'h5: begin
            db = 6'h26;  // 38 dB.
         end
         3'h6: begin
            db = 6'h28;  // 40 dB.
         end
         3'h7: begin
            db = 6'h2a;  // 42 dB.
         end
         default: begin
            db = 6'h18;  // 24 dB.
         end
      endcase
      return db;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Software-visible registers.
   ////////////////////////////////////////////////////////////////////////////////

   localparam logic [7:0] CRG_RST = {bsag_pkg::PRE_KI_RST, bsag_pkg::PRE_KP_RST,
                                     bsag_pkg::POST_KI_RST, bsag_pkg::POST_KP_RST,
                                     bsag_pkg::SAT_RST};
   localparam logic [7:0] GLT_RST = {bsag_pkg::DIGITAL_VGA_CAP_RST, bsag_pkg::FAMP_CAP_RST,
                                     bsag_pkg::AMP_TGT_RST};

   logic [7:0] crg_cfg_q;    // Clock-recovery gain register as written.
   logic [7:0] glt_cfg_q;    // Gain limit and target register as written.
   logic [7:0] crg_act_q;    // Copy in force for the current reception.
   logic [7:0] glt_act_q;    // Copy in force for the current reception.
   logic [7:0] rdata_q;      // Read data register.

   // Writes are accepted in any cycle; this block updates only the software copies.
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         crg_cfg_q <= CRG_RST;
         glt_cfg_q <= GLT_RST;
      end else if (i_reg_wr) begin
         if (i_reg_addr == bsag_pkg::CLK_REC_GAIN_CFG_ADDR) begin
            crg_cfg_q <= i_reg_wdata;
         end else if (i_reg_addr == bsag_pkg::GAIN_LIMIT_TGT_CFG_ADDR) begin
            glt_cfg_q <= i_reg_wdata;
         end
      end
   end

   // Read data comes back one cycle after the strobe; other addresses read zero.
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_q <= 8'h00;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            bsag_pkg::CLK_REC_GAIN_CFG_ADDR: begin
               rdata_q <= crg_cfg_q;
            end
            bsag_pkg::GAIN_LIMIT_TGT_CFG_ADDR: begin
               rdata_q <= glt_cfg_q;
            end
            default: begin
               rdata_q <= bsag_pkg::UNMAPPED_RDATA;
            end
         endcase
      end
   end

   assign o_reg_rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Copies in force, loaded at reception start.
   ////////////////////////////////////////////////////////////////////////////////

   // A mid-reception write must not disturb the running loops, so the copies move
   // only on a reception start. A write in that same cycle is taken too.
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         crg_act_q <= CRG_RST;
         glt_act_q <= GLT_RST;
      end else if (i_rx_start) begin
         if (i_reg_wr && i_reg_addr == bsag_pkg::CLK_REC_GAIN_CFG_ADDR) begin
            crg_act_q <= i_reg_wdata;
         end else begin
            crg_act_q <= crg_cfg_q;
         end
         if (i_reg_wr && i_reg_addr == bsag_pkg::GAIN_LIMIT_TGT_CFG_ADDR) begin
            glt_act_q <= i_reg_wdata;
         end else begin
            glt_act_q <= glt_cfg_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reception phase.
   ////////////////////////////////////////////////////////////////////////////////

   bsag_pkg::bsag_phase_t phase_q;  // Current reception phase.

   // Tracks idle, before sync and after sync. A sync detect in the start cycle
   // wins, so the event is not lost.
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         phase_q <= bsag_pkg::PH_IDLE;
      end else begin
         case (phase_q)
            bsag_pkg::PH_IDLE: begin
               if (i_rx_start && i_sync_det) begin
                  phase_q <= bsag_pkg::PH_POST_SYNC;
               end else if (i_rx_start) begin
                  phase_q <= bsag_pkg::PH_PRE_SYNC;
               end
            end
            bsag_pkg::PH_PRE_SYNC: begin
               if (i_sync_det) begin
                  phase_q <= bsag_pkg::PH_POST_SYNC;
               end else if (i_rx_end) begin
                  phase_q <= bsag_pkg::PH_IDLE;
               end
            end
            bsag_pkg::PH_POST_SYNC: begin
               // A new start without an end begins a fresh search.
               if (i_rx_start && !i_sync_det) begin
                  phase_q <= bsag_pkg::PH_PRE_SYNC;
               end else if (i_rx_end && !i_rx_start) begin
                  phase_q <= bsag_pkg::PH_IDLE;
               end
            end
            default: begin
               phase_q <= bsag_pkg::PH_IDLE;
            end
         endcase
      end
   end

   assign o_post_sync = (phase_q == bsag_pkg::PH_POST_SYNC);

   ////////////////////////////////////////////////////////////////////////////////
   // Effective settings.
   ////////////////////////////////////////////////////////////////////////////////

   // Loop gain selection from the copies in force.
   bsag_loop_gain u_loop_gain (
      .i_pre_ki    (crg_act_q[bsag_pkg::PRE_KI_LSB +: 2]),
      .i_pre_kp    (crg_act_q[bsag_pkg::PRE_KP_LSB +: 2]),
      .i_post_ki   (crg_act_q[bsag_pkg::POST_KI_BIT]),
      .i_post_kp   (crg_act_q[bsag_pkg::POST_KP_BIT]),
      .i_post_sync (o_post_sync),
      .o_ki_halves (o_ki_halves),
      .o_kp_mult   (o_kp_mult)
   );

   assign o_rate_limit = rate_limit_steps(crg_act_q[bsag_pkg::SAT_LSB +: 2]);

   assign o_digital_vga_max = bsag_pkg::DIGITAL_VGA_TOP_SETTING
                       - {1'b0, glt_act_q[bsag_pkg::DIGITAL_VGA_CAP_LSB +: 2]};

   assign o_famp_atten_dd = famp_atten(glt_act_q[bsag_pkg::FAMP_CAP_LSB +: 3]);

   assign o_amp_target_db = amp_target_db(glt_act_q[bsag_pkg::AMP_TGT_LSB +: 3]);

endmodule

// *** verif/bsag_config_properties.sv ***
/* Port checker for the gain configuration bank.
   Assumes one clock and the active-low asynchronous reset. */
`timescale 1ns/1ps
module bsag_config_properties (
   input wire logic       i_sys_clk,
   input wire logic       i_rst_n,
   input wire logic [5:0] i_reg_addr,
   input wire logic       i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   input wire logic       i_rx_start,
   input wire logic       i_rx_end,
   input wire logic       i_sync_det,
   input wire logic       o_post_sync,
   input wire logic [3:0] o_ki_halves,
   input wire logic [2:0] o_kp_mult,
   input wire logic [2:0] o_rate_limit,
   input wire logic [2:0] o_digital_vga_max,
   input wire logic [7:0] o_famp_atten_dd,
   input wire logic [5:0] o_amp_target_db
);
   // One domain, so clock and reset are given once.
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   //////////////////////////////////////////////////////////////////
   // A reception start without a sync word, then a lone sync word.
   sequence s_start;
      i_rx_start && !i_sync_det;
   endsequence
   sequence s_lone_sync;
      i_sync_det && !i_rx_start && !i_rx_end;
   endsequence
   property p_rd_unmap;
      i_reg_rd && !(i_reg_addr inside {6'h19, 6'h1a}) |=> o_reg_rdata == 8'h00;
   endproperty
   a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
   property p_rd_hold;
      !i_reg_rd |=> $stable(o_reg_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_start_pre;
      s_start |=> !o_post_sync;
   endproperty
   a_start_pre: assert property (p_start_pre) else $error("start left post-sync");
   property p_sync_post;
      s_start ##1 s_lone_sync |=> o_post_sync;
   endproperty
   a_sync_post: assert property (p_sync_post) else $error("sync not applied");
   property p_end_idle;
      i_rx_end && !i_rx_start |=> !o_post_sync;
   endproperty
   a_end_idle: assert property (p_end_idle) else $error("end kept post-sync");
   property p_gain_hold;
      !i_rx_start && !i_sync_det && !i_rx_end |=> $stable({o_ki_halves, o_kp_mult,
         o_rate_limit, o_digital_vga_max, o_famp_atten_dd, o_amp_target_db});
   endproperty
   a_gain_hold: assert property (p_gain_hold) else $error("gain moved unasked");
   property p_ki_set;
      o_ki_halves inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8};
   endproperty
   a_ki_set: assert property (p_ki_set) else $error("integral gain illegal");
   property p_rate_set;
      o_rate_limit inside {3'h0, 3'h1, 3'h2, 3'h4};
   endproperty
   a_rate_set: assert property (p_rate_set) else $error("rate limit illegal");
   property p_digital_vga_set;
      o_digital_vga_max >= 3'h4;
   endproperty
   a_digital_vga_set: assert property (p_digital_vga_set) else $error("vga cap illegal");
   property p_amp_set;
      o_amp_target_db inside {6'h18, 6'h1b, 6'h1e, 6'h21, 6'h24, 6'h26, 6'h28, 6'h2a};
   endproperty
   a_amp_set: assert property (p_amp_set) else $error("target illegal");
endmodule
bind bsag_config_top bsag_config_properties u_props (
   .i_sys_clk       (i_sys_clk),
   .i_rst_n         (i_rst_n),
   .i_reg_addr      (i_reg_addr),
   .i_reg_rd        (i_reg_rd),
   .o_reg_rdata     (o_reg_rdata),
   .i_rx_start      (i_rx_start),
   .i_rx_end        (i_rx_end),
   .i_sync_det      (i_sync_det),
   .o_post_sync     (o_post_sync),
   .o_ki_halves     (o_ki_halves),
   .o_kp_mult       (o_kp_mult),
   .o_rate_limit    (o_rate_limit),
   .o_digital_vga_max      (o_digital_vga_max),
   .o_famp_atten_dd (o_famp_atten_dd),
   .o_amp_target_db (o_amp_target_db)
);

// *** verif/bsag_config_top_tb_top.sv ***
/* Self-checking bench for the gain configuration bank.
   Assumes the register and event ports are driven on one 100 MHz clock. */
`timescale 1ns/1ps
module bsag_config_top_tb_top;
   logic       i_sys_clk = 1'b0;
   logic       i_rst_n = 1'b0;
   logic [5:0] i_reg_addr = 6'h00;
   logic       i_reg_wr = 1'b0;
   logic [7:0] i_reg_wdata = 8'h00;
   logic       i_reg_rd = 1'b0;
   logic [7:0] o_reg_rdata;
   logic       i_rx_start = 1'b0;
   logic       i_rx_end = 1'b0;
   logic       i_sync_det = 1'b0;
   logic       o_post_sync;
   logic [3:0] o_ki_halves;
   logic [2:0] o_kp_mult, o_rate_limit, o_digital_vga_max;
   logic [7:0] o_famp_atten_dd;
   logic [5:0] o_amp_target_db;
   int         fail_count = 0;
   int         checks_done = 0;
   int         cyc = 0;
   // Expected decodes of the field codes.
   logic [7:0] famp_tab [8] = '{8'h00, 8'h1a, 8'h3d, 8'h4a, 8'h5c, 8'h73, 8'h92, 8'hab};
   logic [5:0] tgt_tab [8] = '{6'h18, 6'h1b, 6'h1e, 6'h21, 6'h24, 6'h26, 6'h28, 6'h2a};
   logic [2:0] rate_tab [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
   logic [7:0] pre [6];
   logic [7:0] pst [6];
   bsag_config_top dut (
      .i_sys_clk       (i_sys_clk),
      .i_rst_n         (i_rst_n),
      .i_reg_addr      (i_reg_addr),
      .i_reg_wr        (i_reg_wr),
      .i_reg_wdata     (i_reg_wdata),
      .i_reg_rd        (i_reg_rd),
      .o_reg_rdata     (o_reg_rdata),
      .i_rx_start      (i_rx_start),
      .i_rx_end        (i_rx_end),
      .i_sync_det      (i_sync_det),
      .o_post_sync     (o_post_sync),
      .o_ki_halves     (o_ki_halves),
      .o_kp_mult       (o_kp_mult),
      .o_rate_limit    (o_rate_limit),
      .o_digital_vga_max      (o_digital_vga_max),
      .o_famp_atten_dd (o_famp_atten_dd),
      .o_amp_target_db (o_amp_target_db)
   );
   // Clock at 100 MHz.
   always #5 i_sys_clk = ~i_sys_clk;
   //////////////////////////////////////////////////////////////////
   // Compare one value and count it.
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      if (fail_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Cut a hang short.
   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         end_of_test();
      end
   end
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_sys_clk);
      i_reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      @(posedge i_sys_clk);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_reg_rd <= 1'b0;
      #1 chk(o_reg_rdata, e);
   endtask
   // One-cycle event pulse: 0 start, 1 sync, 2 end.
   task automatic ev(input int k);
      @(posedge i_sys_clk);
      i_rx_start <= (k == 0);
      i_sync_det <= (k == 1);
      i_rx_end <= (k == 2);
      @(posedge i_sys_clk);
      {i_rx_start, i_sync_det, i_rx_end} <= 3'h0;
      #1;
   endtask
   // Compare all gain outputs and the phase flag.
   task automatic outs(input logic [7:0] e [6], input logic ps);
      chk({7'h0, o_post_sync}, {7'h0, ps});
      chk({4'h0, o_ki_halves}, e[0]);
      chk({5'h0, o_kp_mult}, e[1]);
      chk({5'h0, o_rate_limit}, e[2]);
      chk({5'h0, o_digital_vga_max}, e[3]);
      chk(o_famp_atten_dd, e[4]);
      chk({2'h0, o_amp_target_db}, e[5]);
   endtask
   initial begin
      pre = '{8'h04, 8'h03, 8'h00, 8'h07, 8'h00, 8'h21};
      repeat (16) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      outs(pre, 1'b0);
      rd(6'h19, 8'h6c);
      rd(6'h1a, 8'h03);
      wr(6'h1b, 8'hff);
      rd(6'h1b, 8'h00);
      ev(1);
      outs(pre, 1'b0);
      for (int i = 0; i < 8; i++) begin
         wr(6'h19, {i[1:0], i[2:1], i[2], i[0], i[1:0]});
         wr(6'h1a, {i[1:0], i[2:0], 3'(7 - i)});
         rd(6'h19, {i[1:0], i[2:1], i[2], i[0], i[1:0]});
         rd(6'h1a, {i[1:0], i[2:0], 3'(7 - i)});
         outs(pre, 1'b0);
         pre[0] = {5'h0, i[1:0], 1'b0} + 8'h02;
         pre[1] = {6'h0, i[2:1]} + 8'h01;
         pre[2] = {5'h0, rate_tab[i[1:0]]};
         pre[3] = {5'h0, 3'h7 - {1'b0, i[1:0]}};
         pre[4] = famp_tab[i[2:0]];
         pre[5] = {2'h0, tgt_tab[3'(7 - i)]};
         pst = pre;
         pst[0] = i[2] ? 8'h01 : pre[0];
         pst[1] = i[0] ? 8'h01 : pre[1];
         ev(0);
         outs(pre, 1'b0);
         ev(1);
         outs(pst, 1'b1);
         if (i[0]) begin
            ev(0);
         end else begin
            ev(2);
         end
         outs(pre, 1'b0);
      end
      // Write taken together with a start, then sync on the very next edge.
      @(posedge i_sys_clk);
      i_reg_addr <= 6'h1a;
      i_reg_wdata <= 8'hc0;
      i_reg_wr <= 1'b1;
      i_rx_start <= 1'b1;
      @(posedge i_sys_clk);
      i_reg_wr <= 1'b0;
      i_rx_start <= 1'b0;
      i_sync_det <= 1'b1;
      #1 chk({5'h0, o_digital_vga_max}, 8'h04);
      @(posedge i_sys_clk);
      i_sync_det <= 1'b0;
      #1 chk({7'h0, o_post_sync}, 8'h01);
      ev(2);
      chk({7'h0, o_post_sync}, 8'h00);
      end_of_test();
   end
endmodule
